// ===== logic/scru_pkg.sv
// Package of types and constants for the signed compare and range unit.
package scru_pkg;

    // ===========================================================
    // Operation codes
    localparam logic [7:0] OP_LESS_EQUAL_WORD = 8'h36;
    localparam logic [7:0] OP_LESS_EQUAL_DOUBLE = 8'h4A;
    localparam logic [7:0] OP_LESS_THAN_WORD = 8'h38;
    localparam logic [7:0] OP_LESS_THAN_DOUBLE = 8'h4C;
    localparam logic [7:0] OP_RANGE_CHECK_INT = 8'h8C;
    localparam logic [7:0] OP_RANGE_CHECK_DOUBLE_SIGNED_INT = 8'h8D;
    localparam logic [7:0] OP_RANGE_CHECK_WORD = 8'h8E;

    // ===========================================================
    // Widths, fields and reset values
    localparam int WORD_W = 16;
    localparam int WORD_CNT = 6;
    localparam int LOW_WORD_LSB = 0;
    localparam int HIGH_WORD_LSB = 16;
    localparam logic RESULT_RESET = 1'b0;
    localparam logic [1:0] FETCH_LAT = 2'h1;

    // ===========================================================
    // Request and answer carriers
    typedef struct packed {
        logic enable;
        logic [7:0] opCode;
        logic [2:0] addrOne;
        logic [2:0] addrTwo;
        logic [2:0] addrThree;
    } scru_req_t;

    typedef struct packed {
        logic done;
        logic powerFlow;
        logic badOp;
    } scru_rsp_t;

    typedef struct packed {
        logic we;
        logic [2:0] addr;
        logic [15:0] data;
    } scru_wr_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_EVAL
    } scru_state_t;

endpackage

// ===== logic/scru_word_mem.sv
// Small operand word memory with registered read data.
`timescale 1ns/10ps
module scru_word_mem
    import scru_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire scru_wr_t wr,
    input wire logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WORD_W-1:0] rdData
);
    initial begin
        if (DEPTH < 2) begin
            $error("DEPTH must be at least 2");
        end
    end

    logic [WORD_W-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr.we) begin
            mem[wr.addr[$clog2(DEPTH)-1:0]] <= wr.data;
        end
        rdData <= mem[rdAddr];
    end
endmodule

// ===== logic/scru_top.sv
// Signed compare and range unit: operand fetch, decode and power-flow result.
`timescale 1ns/10ps
// Functional notes
// - Word less-or-equal compares 16-bit signed operands, output only when enabled.
// - Double less-or-equal compares 32-bit signed operands when enabled.
// - Double operand spans two words; lower address holds low half.
// - Code 54 is word less-or-equal, 74 is double less-or-equal.
// - Codes 140, 141, 142 are int, double_signed_int and word range checks.
// - Range output is 1 when input inside limits inclusive, else 0.
// - Either limit may be the smaller; result is the same.
// - Range supports int, double_signed_int and word types; int is the default.
// - Strict less-than stays low when operands are equal.
// - Code 56 is word less-than, 76 is double less-than.
module scru_top
    import scru_pkg::*;
#(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire scru_req_t req,
    input wire scru_wr_t wr,
    output scru_rsp_t rsp
);
    initial begin
        if (DEPTH != 8) begin
            $error("DEPTH must be 8 to match 3-bit operand addresses");
        end
    end

    // ===========================================================
    // State
    // Operands live in one flat vector so that the whole state stays a single packed struct.
    typedef struct packed {
        scru_state_t st;
        logic [7:0] op;
        logic [8:0] addrs;
        logic [1:0] idx;
        logic half;
        logic [95:0] vals;
        scru_rsp_t rsp;
    } scru_flat_t;

    scru_flat_t s_q;
    scru_flat_t s_d;
    logic [2:0] rdAddr;
    logic [WORD_W-1:0] rdData;

    scru_word_mem #(
        .DEPTH(DEPTH)
    ) u_mem (
        .clk(clk),
        .wr(wr),
        .rdAddr(rdAddr),
        .rdData(rdData)
    );

    // ===========================================================
    // Decode
    logic isDouble;
    logic isRange;
    logic isKnown;
    logic [1:0] opndCnt;

    always_comb begin
        isDouble = 1'b0;
        isRange = 1'b0;
        isKnown = 1'b1;
        case (s_q.op)
            OP_LESS_EQUAL_WORD, OP_LESS_THAN_WORD: begin
                isDouble = 1'b0;
            end
            OP_LESS_EQUAL_DOUBLE, OP_LESS_THAN_DOUBLE: begin
                isDouble = 1'b1;
            end
            OP_RANGE_CHECK_INT, OP_RANGE_CHECK_WORD: begin
                isRange = 1'b1;
            end
            OP_RANGE_CHECK_DOUBLE_SIGNED_INT: begin
                isRange = 1'b1;
                isDouble = 1'b1;
            end
            default: begin
                isKnown = 1'b0;
            end
        endcase
        opndCnt = isRange ? 2'h3 : 2'h2;
    end

    // ===========================================================
    // Evaluate
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] x;
    logic result;

    always_comb begin
        a = s_q.vals[31:0];
        b = s_q.vals[63:32];
        x = s_q.vals[95:64];
        result = 1'b0;
        case (s_q.op)
            OP_LESS_EQUAL_WORD: result = $signed(a[15:0]) <= $signed(b[15:0]);
            OP_LESS_EQUAL_DOUBLE: result = $signed(a) <= $signed(b);
            OP_LESS_THAN_WORD: result = $signed(a[15:0]) < $signed(b[15:0]);
            OP_LESS_THAN_DOUBLE: result = $signed(a) < $signed(b);
            OP_RANGE_CHECK_INT: begin
                result = ($signed(x[15:0]) >= $signed(a[15:0])
                          && $signed(x[15:0]) <= $signed(b[15:0]))
                      || ($signed(x[15:0]) >= $signed(b[15:0])
                          && $signed(x[15:0]) <= $signed(a[15:0]));
            end
            OP_RANGE_CHECK_DOUBLE_SIGNED_INT: begin
                result = ($signed(x) >= $signed(a) && $signed(x) <= $signed(b))
                      || ($signed(x) >= $signed(b) && $signed(x) <= $signed(a));
            end
            OP_RANGE_CHECK_WORD: begin
                result = (x[15:0] >= a[15:0] && x[15:0] <= b[15:0])
                      || (x[15:0] >= b[15:0] && x[15:0] <= a[15:0]);
            end
            default: result = 1'b0;
        endcase
    end

    // ===========================================================
    // Sequencer
    logic [2:0] curAddr;

    always_comb begin
        case (s_q.idx)
            2'h0: curAddr = s_q.addrs[2:0];
            2'h1: curAddr = s_q.addrs[5:3];
            default: curAddr = s_q.addrs[8:6];
        endcase
        rdAddr = curAddr + {2'h0, s_q.half};
    end

    always_comb begin
        s_d = s_q;
        s_d.rsp.done = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (req.enable) begin
                    s_d.op = req.opCode;
                    s_d.addrs = {req.addrThree, req.addrTwo, req.addrOne};
                    s_d.idx = 2'h0;
                    s_d.half = 1'b0;
                    s_d.vals = '0;
                    s_d.st = ST_LOW;
                end else begin
                    s_d.rsp.powerFlow = 1'b0;
                end
            end
            ST_LOW: begin
                // Memory read data appear one edge after the address.
                s_d.st = ST_HIGH;
            end
            ST_HIGH: begin
                if (!isKnown) begin
                    s_d.rsp.badOp = 1'b1;
                    s_d.rsp.powerFlow = 1'b0;
                    s_d.rsp.done = 1'b1;
                    s_d.st = ST_IDLE;
                end else begin
                    if (s_q.half) begin
                        s_d.vals[32*s_q.idx + 16 +: 16] = rdData;
                    end else if (isDouble) begin
                        s_d.vals[32*s_q.idx +: 16] = rdData;
                    end else begin
                        s_d.vals[32*s_q.idx +: 32] = {{16{rdData[15]}}, rdData};
                    end
                    if (isDouble && !s_q.half) begin
                        s_d.half = 1'b1;
                        s_d.st = ST_LOW;
                    end else if (s_q.idx + 2'h1 == opndCnt) begin
                        s_d.st = ST_EVAL;
                    end else begin
                        s_d.half = 1'b0;
                        s_d.idx = s_q.idx + 2'h1;
                        s_d.st = ST_LOW;
                    end
                end
            end
            ST_EVAL: begin
                s_d.rsp.badOp = 1'b0;
                s_d.rsp.powerFlow = result;
                s_d.rsp.done = 1'b1;
                s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.rsp.powerFlow <= RESULT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rsp = s_q.rsp;
endmodule

// ===== bench/scru_assertions.sv
// Timing and result-flag checker for the compare and range unit.
`timescale 1ns/10ps
module scru_assertions
    import scru_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire scru_req_t req,
    input wire scru_wr_t wr,
    input wire scru_rsp_t rsp
);
    // ========
    // Busy tracking
    logic busy_q;
    logic take;
    // The unit may take a new request at the very edge at which done is seen.
    assign take = (!busy_q || rsp.done) && req.enable;
    always_ff @(posedge clk) begin
        busy_q <= rst_n && (take || (busy_q && !rsp.done));
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence taken_s(logic [7:0] op);
        take && req.opCode == op;
    endsequence
    le_word_lat_a: assert property (taken_s(OP_LESS_EQUAL_WORD) |-> ##1 !rsp.done [*5] ##1 rsp.done)
        else $error("word compare late or early");
    lt_word_lat_a: assert property (taken_s(OP_LESS_THAN_WORD) |-> ##1 !rsp.done [*5] ##1 rsp.done)
        else $error("word less-than late or early");
    le_double_lat_a: assert property (taken_s(OP_LESS_EQUAL_DOUBLE) |-> ##10 rsp.done)
        else $error("double compare latency wrong");
    lt_double_lat_a: assert property (taken_s(OP_LESS_THAN_DOUBLE) |-> ##10 rsp.done)
        else $error("double less-than latency wrong");
    range_int_lat_a: assert property (taken_s(OP_RANGE_CHECK_INT) |-> ##8 rsp.done)
        else $error("range latency wrong");
    range_word_lat_a: assert property (taken_s(OP_RANGE_CHECK_WORD) |-> ##8 rsp.done)
        else $error("word range latency wrong");
    range_double_signed_int_lat_a: assert property (taken_s(OP_RANGE_CHECK_DOUBLE_SIGNED_INT) |-> ##14 rsp.done)
        else $error("double range latency wrong");
    done_pulse_a: assert property (rsp.done |=> !rsp.done)
        else $error("done longer than one cycle");
    flow_with_done_a: assert property ($rose(rsp.powerFlow) |-> rsp.done)
        else $error("result rose without done");
    flow_gate_a: assert property (!busy_q && !req.enable |=> !rsp.powerFlow)
        else $error("result high without enable");
    bad_op_a: assert property ($rose(rsp.badOp) |-> rsp.done && !rsp.powerFlow)
        else $error("bad opcode flag wrong");
endmodule
bind scru_top scru_assertions scru_assertions_inst (.clk(clk), .rst_n(rst_n), .req(req),
    .wr(wr), .rsp(rsp));

// ===== bench/scru_ladder_model.sv
// Ladder-logic model that powers the enable input and holds a request until done.
`timescale 1ns/10ps
module scru_ladder_model
    import scru_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire scru_req_t cmd,
    input wire scru_rsp_t rsp,
    output scru_req_t req
);
    // ========
    // Request hold
    // whole request
    // Enable stands for the one edge at which the idle unit takes the request; held any
    // longer, it would be taken a second time at the edge after done.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req <= '0;
        end else if (start) begin
            req <= cmd;
        end else if (req.enable) begin
            req.enable <= 1'b0;
        end else if (rsp.done) begin
            // Released fields flip so a stale operand is never read as live.
            req <= {1'b0, ~req[16:0]};
        end
    end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the signed compare and range unit.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %0t result differs", $time); end end
module tb;
    import scru_pkg::*;
    logic clk;
    logic rst_n;
    logic start;
    scru_req_t cmd;
    scru_req_t req;
    scru_wr_t wr;
    scru_rsp_t rsp;
    logic [15:0] mem [8];
    logic [31:0] r;
    int err_count;
    int tests_run;
    int seed;
    logic [7:0] ops [8] = '{OP_LESS_EQUAL_WORD, OP_LESS_EQUAL_DOUBLE, OP_LESS_THAN_WORD,
        OP_LESS_THAN_DOUBLE, OP_RANGE_CHECK_INT, OP_RANGE_CHECK_DOUBLE_SIGNED_INT, OP_RANGE_CHECK_WORD, 8'h00};
    scru_top #(.DEPTH(8)) scru_top_inst (.clk(clk), .rst_n(rst_n), .req(req), .wr(wr), .rsp(rsp));
    scru_ladder_model scru_ladder_model_inst (.clk(clk), .rst_n(rst_n), .start(start), .cmd(cmd),
        .rsp(rsp), .req(req));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ========
    // Expected results
    function automatic logic signed [32:0] sx(logic [2:0] a);
        return $signed({{17{mem[a][15]}}, mem[a]});
    endfunction
    function automatic logic signed [32:0] dx(logic [2:0] a);
        return $signed({mem[a + 3'h1][15], mem[a + 3'h1], mem[a]});
    endfunction
    function automatic logic signed [32:0] ux(logic [2:0] a);
        return $signed({17'h0, mem[a]});
    endfunction
    function automatic logic inRange(logic signed [32:0] a, b, x);
        return (a <= x && x <= b) || (b <= x && x <= a);
    endfunction
    function automatic logic expFlow(logic [7:0] op, logic [2:0] p1, p2, p3);
        case (op)
            OP_LESS_EQUAL_WORD: return sx(p1) <= sx(p2);
            OP_LESS_THAN_WORD: return sx(p1) < sx(p2);
            OP_LESS_EQUAL_DOUBLE: return dx(p1) <= dx(p2);
            OP_LESS_THAN_DOUBLE: return dx(p1) < dx(p2);
            OP_RANGE_CHECK_INT: return inRange(sx(p1), sx(p2), sx(p3));
            OP_RANGE_CHECK_DOUBLE_SIGNED_INT: return inRange(dx(p1), dx(p2), dx(p3));
            OP_RANGE_CHECK_WORD: return inRange(ux(p1), ux(p2), ux(p3));
            default: return 1'b0;
        endcase
    endfunction
    task automatic wrWord(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= '{we: 1'b1, addr: a, data: d};
        mem[a] = d;
    endtask
    task automatic doOp(input logic [7:0] op, input logic [2:0] a1, a2, a3);
        logic ok;
        logic want;
        want = expFlow(op, a1, a2, a3);
        ok = 1'b0;
        @(posedge clk);
        wr.we <= 1'b0;
        start <= 1'b1;
        cmd <= '{enable: 1'b1, opCode: op, addrOne: a1, addrTwo: a2, addrThree: a3};
        @(posedge clk);
        start <= 1'b0;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            #1;
            ok = rsp.done === 1'b1;
        end
        `CHK(ok, 1'b1)
        `CHK(rsp.powerFlow, want)
        `CHK(rsp.badOp, op == 8'h00)
        repeat (2) @(posedge clk);
        #1;
        `CHK(rsp.powerFlow, 1'b0)
        $display("test done op %0d", op);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        conclude();
    end
    initial begin
        seed = 74058;
        err_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        start = 1'b0;
        cmd = '0;
        wr = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CHK(rsp, 3'h0)
        // Equal operands, swapped limits on a boundary, and a signed-versus-unsigned word range.
        foreach (mem[k]) wrWord(3'(k), (k < 2) ? 16'h8000 : 16'h0064 >> (k & 1) * 7);
        wrWord(3'h5, 16'hFFFF);
        wrWord(3'h6, 16'h0001);
        foreach (ops[i]) begin
            doOp(ops[i], 3'h0, 3'h1, 3'h2);
            doOp(ops[i], 3'h2, 3'h3, 3'h4);
            doOp(ops[i], 3'h5, 3'h6, 3'h3);
        end
        // A reset in the middle of an evaluation abandons it and clears the stale error flag.
        @(posedge clk);
        start <= 1'b1;
        cmd <= '{enable: 1'b1, opCode: OP_RANGE_CHECK_DOUBLE_SIGNED_INT, addrOne: 3'h0, addrTwo: 3'h2,
            addrThree: 3'h4};
        @(posedge clk);
        start <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        `CHK(rsp, 3'h0)
        $display("test done mid-run reset");
        repeat (30) begin
            foreach (mem[k]) wrWord(3'(k), 16'($random(seed)));
            r = $random(seed);
            doOp(ops[r[2:0]], r[5:3] % 3'd7, r[8:6] % 3'd7, r[11:9] % 3'd7);
        end
        conclude();
    end
endmodule
